// ### hw/ccm_top.v
// Command interpreter driving a two-wire register bus master.
// Assumes the host loads parameter bytes before pulsing cmd_valid and
// that host_lock_held and active_sensor_bus_addr share this clock.
//
// Overview of operation
// - Config speed field is bus rate in hertz
// - Bus rate defaults to 400000 hertz
// - Code 0x8d04 selects target, one byte
// - Target byte: 7-bit address plus R/W bit
// - Target byte zero selects active sensor address
// - Select answers ENOERR, or EBUSY while busy
// - Selected target persists for later transfers
// - Code 0x8d05 reads: address, then length
// - Read length outside 1..22 gives ERANGE
// - Transfers accept at once; EBUSY while running
// - Code 0x8d06 writes 1..19 bytes in order
// - Bad write length gives ERANGE, no transfer
// - Code 0x8d07 takes address, data, mask
// - Update: read, clear mask bits, OR data
// - Code 0x8d08 reports done, absent, aborted, busy
// - Read data returned only after successful read
// - Without bus lock these commands give EACCES
// - Multi-byte values are most significant first
// - Speed outside 100000..400000 gives EINVAL
`timescale 1ns/1ps
`include "ccm_defines.vh"
module ccm_top (
	input wire clock,
	input wire rst,
	input wire host_lock_held,
	input wire [7:0] active_sensor_bus_addr,
	input wire param_wr,
	input wire [4:0] param_addr,
	input wire [7:0] param_wdata,
	input wire cmd_valid,
	input wire [15:0] cmd_code,
	output reg rsp_valid,
	output reg [7:0] rsp_status,
	output reg [4:0] rsp_len,
	input wire [4:0] rsp_rd_addr,
	output reg [7:0] rsp_rd_data,
	input wire scl_in,
	output wire scl_out,
	output wire scl_oe,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe
);
	localparam [31:0] QDIV_FULL = `CCM_QDIV_DEF;
	localparam S_IDLE = 2'h0;
	localparam S_DIV = 2'h1;
	localparam S_ISSUE = 2'h2;
	localparam S_WAIT = 2'h3;
	localparam T_START = 4'h0;
	localparam T_SLAW = 4'h1;
	localparam T_RAH = 4'h2;
	localparam T_RAL = 4'h3;
	localparam T_WDAT = 4'h4;
	localparam T_RSTART = 4'h5;
	localparam T_SLAR = 4'h6;
	localparam T_RDAT = 4'h7;
	localparam T_STOP = 4'h8;
	localparam K_NONE = 2'h0;
	localparam K_READ = 2'h1;
	localparam K_WRITE = 2'h2;
	localparam K_UPDATE = 2'h3;

	function [15:0] be16;
		input [7:0] hi;
		input [7:0] lo;
		be16 = {hi, lo};
	endfunction

	reg [7:0] pool [0:21];
	reg [7:0] buf_mem [0:21];
	reg scl_m_reg, scl_s_reg, sda_m_reg, sda_s_reg;
	reg pin_low_reg;
	reg [1:0] state_reg;
	reg [3:0] step_reg;
	reg [1:0] kind_reg;
	reg upd_wr_reg;
	reg busy_reg;
	reg [4:0] len_reg;
	reg [4:0] idx_reg;
	reg [7:0] txn_status_reg;
	reg [7:0] err_reg;
	reg [7:0] target_reg;
	reg [15:0] reg_addr_reg;
	reg [15:0] upd_data_reg;
	reg [15:0] upd_mask_reg;
	reg [31:0] bus_speed_hz;
	reg [7:0] quarter_reg;
	reg [25:0] acc_reg;
	reg [25:0] inc_reg;
	reg [7:0] cnt_reg;
	reg eng_go_reg;
	reg [1:0] eng_op_reg;
	reg [7:0] eng_tx_reg;
	reg eng_ack_reg;
	integer i;

	wire tick, eng_busy, eng_done, eng_nack, eng_arb;
	wire [7:0] eng_rx;
	wire [31:0] cfg_speed = {pool[0], pool[1], pool[2], pool[3]};
	wire [7:0] req_len = pool[`CCM_OFF_LEN];
	wire cmd_known = (cmd_code >= `CCM_CMD_CONFIG) &&
		(cmd_code <= `CCM_CMD_STATUS);
	wire [15:0] old_val = be16(buf_mem[0], buf_mem[1]);
	wire [15:0] new_val = (old_val & ~upd_mask_reg) | upd_data_reg;
	wire last_byte = (idx_reg == len_reg - 5'h01);
	wire addr_phase = (step_reg == T_SLAW) || (step_reg == T_RAH) ||
		(step_reg == T_RAL) || (step_reg == T_SLAR) ||
		(step_reg == T_WDAT);
	wire go_read = (kind_reg == K_READ) ||
		(kind_reg == K_UPDATE && !upd_wr_reg);

	assign scl_out = pin_low_reg;
	assign sda_out = pin_low_reg;

	ccm_qtick u_qtick (
		.clock(clock),
		.rst(rst),
		.run(eng_busy),
		.quarter(quarter_reg),
		.tick(tick)
	);

	ccm_link u_link (
		.clock(clock),
		.rst(rst),
		.tick(tick),
		.go(eng_go_reg),
		.op(eng_op_reg),
		.tx_byte(eng_tx_reg),
		.ack_out(eng_ack_reg),
		.scl_s(scl_s_reg),
		.sda_s(sda_s_reg),
		.busy(eng_busy),
		.done(eng_done),
		.rx_byte(eng_rx),
		.nack(eng_nack),
		.arb_lost(eng_arb),
		.scl_oe(scl_oe),
		.sda_oe(sda_oe)
	);

	always @(posedge clock) begin
		if (rst) begin
			scl_m_reg <= 1'b1;
			scl_s_reg <= 1'b1;
			sda_m_reg <= 1'b1;
			sda_s_reg <= 1'b1;
		end else begin
			scl_m_reg <= scl_in;
			scl_s_reg <= scl_m_reg;
			sda_m_reg <= sda_in;
			sda_s_reg <= sda_m_reg;
		end
	end

	always @(posedge clock) begin
		if (param_wr && param_addr < `CCM_POOL_BYTES)
			pool[param_addr] <= param_wdata;
	end

	always @(posedge clock) begin
		if (rst)
			rsp_rd_data <= 8'h00;
		else if (rsp_rd_addr < `CCM_POOL_BYTES)
			rsp_rd_data <= buf_mem[rsp_rd_addr];
		else
			rsp_rd_data <= 8'h00;
	end

	always @(posedge clock) begin
		rsp_valid <= 1'b0;
		eng_go_reg <= 1'b0;
		if (rst) begin
			pin_low_reg <= 1'b0;
			rsp_status <= `CCM_ST_ENOERR;
			rsp_len <= 5'h00;
			state_reg <= S_IDLE;
			step_reg <= T_START;
			kind_reg <= K_NONE;
			upd_wr_reg <= 1'b0;
			busy_reg <= 1'b0;
			len_reg <= 5'h00;
			idx_reg <= 5'h00;
			txn_status_reg <= `CCM_ST_ENOERR;
			err_reg <= `CCM_ST_ENOERR;
			target_reg <= 8'h00;
			reg_addr_reg <= 16'h0000;
			upd_data_reg <= 16'h0000;
			upd_mask_reg <= 16'h0000;
			bus_speed_hz <= `CCM_SPEED_DEF;
			quarter_reg <= QDIV_FULL[7:0];
			acc_reg <= 26'h0000000;
			inc_reg <= 26'h0000000;
			cnt_reg <= 8'h00;
			eng_op_reg <= `CCM_OP_START;
			eng_tx_reg <= 8'h00;
			eng_ack_reg <= 1'b0;
		end else begin
			if (cmd_valid) begin
				rsp_valid <= 1'b1;
				rsp_len <= 5'h00;
				if (!cmd_known)
					rsp_status <= `CCM_ST_EINVAL;
				else if (!host_lock_held)
					rsp_status <= `CCM_ST_EACCES;
				else if (cmd_code == `CCM_CMD_STATUS) begin
					rsp_status <= txn_status_reg;
					if (kind_reg == K_READ && !busy_reg &&
						txn_status_reg == `CCM_ST_ENOERR)
						rsp_len <= len_reg;
				end else if (busy_reg || state_reg != S_IDLE)
					rsp_status <= `CCM_ST_EBUSY;
				else begin
					rsp_status <= `CCM_ST_ENOERR;
					case (cmd_code)
					`CCM_CMD_CONFIG: begin
						if (cfg_speed < `CCM_SPEED_MIN ||
							cfg_speed > `CCM_SPEED_MAX)
							rsp_status <= `CCM_ST_EINVAL;
						else begin
							// Answer waits for the divisor search
							rsp_valid <= 1'b0;
							bus_speed_hz <= cfg_speed;
							acc_reg <= `CCM_CLK_HZ;
							inc_reg <= {cfg_speed[23:0], 2'b00};
							cnt_reg <= 8'h00;
							state_reg <= S_DIV;
						end
					end
					`CCM_CMD_SELECT: begin
						if (pool[`CCM_OFF_TARGET] == 8'h00)
							target_reg <= active_sensor_bus_addr;
						else
							target_reg <= pool[`CCM_OFF_TARGET];
					end
					`CCM_CMD_READ, `CCM_CMD_WRITE: begin
						if (req_len < `CCM_LEN_MIN ||
							req_len > ((cmd_code == `CCM_CMD_READ) ?
							`CCM_RD_MAX : `CCM_WR_MAX))
							rsp_status <= `CCM_ST_ERANGE;
						else begin
							kind_reg <= (cmd_code == `CCM_CMD_READ) ?
								K_READ : K_WRITE;
							len_reg <= req_len[4:0];
							reg_addr_reg <= be16(pool[0], pool[1]);
							// Copy so host may refill the pool mid-transfer
							for (i = 0; i < 19; i = i + 1)
								buf_mem[i] <= pool[i + 3];
							state_reg <= S_ISSUE;
							step_reg <= T_START;
							busy_reg <= 1'b1;
							upd_wr_reg <= 1'b0;
							err_reg <= `CCM_ST_ENOERR;
							txn_status_reg <= `CCM_ST_EBUSY;
						end
					end
					default: begin
						kind_reg <= K_UPDATE;
						len_reg <= 5'h02;
						reg_addr_reg <= be16(pool[0], pool[1]);
						upd_data_reg <= be16(pool[`CCM_OFF_UDATA],
							pool[`CCM_OFF_UDATA + 5'h01]);
						upd_mask_reg <= be16(pool[`CCM_OFF_UMASK],
							pool[`CCM_OFF_UMASK + 5'h01]);
						state_reg <= S_ISSUE;
						step_reg <= T_START;
						busy_reg <= 1'b1;
						upd_wr_reg <= 1'b0;
						err_reg <= `CCM_ST_ENOERR;
						txn_status_reg <= `CCM_ST_EBUSY;
					end
					endcase
				end
			end

			case (state_reg)
			S_DIV: begin
				// Rounds up, so the bus never runs above the asked rate
				if (acc_reg == 26'h0000000) begin
					quarter_reg <= cnt_reg;
					rsp_valid <= 1'b1;
					rsp_status <= `CCM_ST_ENOERR;
					rsp_len <= 5'h00;
					state_reg <= S_IDLE;
				end else begin
					acc_reg <= (acc_reg > inc_reg) ?
						acc_reg - inc_reg : 26'h0000000;
					cnt_reg <= cnt_reg + 8'h01;
				end
			end
			S_ISSUE: begin
				eng_go_reg <= 1'b1;
				eng_ack_reg <= !last_byte;
				eng_tx_reg <= 8'h00;
				case (step_reg)
				T_START, T_RSTART: eng_op_reg <= `CCM_OP_START;
				T_STOP: eng_op_reg <= `CCM_OP_STOP;
				T_RDAT: eng_op_reg <= `CCM_OP_RD;
				default: eng_op_reg <= `CCM_OP_WR;
				endcase
				case (step_reg)
				T_SLAW: eng_tx_reg <= {target_reg[7:1], 1'b0};
				T_SLAR: eng_tx_reg <= {target_reg[7:1], 1'b1};
				T_RAH: eng_tx_reg <= reg_addr_reg[15:8];
				T_RAL: eng_tx_reg <= reg_addr_reg[7:0];
				T_WDAT: begin
					if (kind_reg == K_UPDATE)
						eng_tx_reg <= (idx_reg == 5'h00) ?
							new_val[15:8] : new_val[7:0];
					else
						eng_tx_reg <= buf_mem[idx_reg];
				end
				default: eng_tx_reg <= 8'h00;
				endcase
				state_reg <= S_WAIT;
			end
			S_WAIT: begin
				if (eng_done) begin
					state_reg <= S_ISSUE;
					if (eng_arb) begin
						// Bus is lost; the winner owns the stop condition
						busy_reg <= 1'b0;
						txn_status_reg <= `CCM_ST_EIO;
						state_reg <= S_IDLE;
					end else if (eng_nack && addr_phase) begin
						err_reg <= `CCM_ST_ENOENT;
						step_reg <= T_STOP;
					end else begin
						case (step_reg)
						T_START: step_reg <= T_SLAW;
						T_SLAW: step_reg <= T_RAH;
						T_RAH: step_reg <= T_RAL;
						T_RAL: begin
							idx_reg <= 5'h00;
							step_reg <= go_read ? T_RSTART : T_WDAT;
						end
						T_RSTART: step_reg <= T_SLAR;
						T_SLAR: begin
							idx_reg <= 5'h00;
							step_reg <= T_RDAT;
						end
						T_WDAT, T_RDAT: begin
							if (step_reg == T_RDAT)
								buf_mem[idx_reg] <= eng_rx;
							idx_reg <= idx_reg + 5'h01;
							if (last_byte)
								step_reg <= T_STOP;
						end
						default: begin
							if (err_reg == `CCM_ST_ENOERR &&
								kind_reg == K_UPDATE && !upd_wr_reg) begin
								upd_wr_reg <= 1'b1;
								step_reg <= T_START;
							end else begin
								busy_reg <= 1'b0;
								txn_status_reg <= err_reg;
								state_reg <= S_IDLE;
							end
						end
						endcase
					end
				end
			end
			default: begin
			end
			endcase
		end
	end
endmodule

// ### common/ccm_defines.vh
// Constants shared by the bus master command block.
// Included by name; holds definitions only.
`ifndef CCM_DEFINES_VH
`define CCM_DEFINES_VH
`define CCM_CLK_HZ 26'd50000000
`define CCM_SPEED_MIN 32'd100000
`define CCM_SPEED_MAX 32'd400000
`define CCM_SPEED_DEF 32'd400000
// Quarter bit period in clocks at the default rate, rounded up
`define CCM_QDIV_DEF ((50000000 + 4 * 400000 - 1) / (4 * 400000))
`define CCM_CMD_CONFIG 16'h8d03
`define CCM_CMD_SELECT 16'h8d04
`define CCM_CMD_READ 16'h8d05
`define CCM_CMD_WRITE 16'h8d06
`define CCM_CMD_UPDATE 16'h8d07
`define CCM_CMD_STATUS 16'h8d08
`define CCM_OFF_TARGET 5'h00
`define CCM_OFF_ADDR 5'h00
`define CCM_OFF_LEN 5'h02
`define CCM_OFF_WDATA 5'h03
`define CCM_OFF_UDATA 5'h02
`define CCM_OFF_UMASK 5'h04
`define CCM_POOL_BYTES 5'h16
`define CCM_LEN_MIN 8'h01
`define CCM_RD_MAX 8'h16
`define CCM_WR_MAX 8'h13
`define CCM_ST_ENOERR 8'h00
`define CCM_ST_ENOENT 8'h02
`define CCM_ST_EIO 8'h05
`define CCM_ST_EACCES 8'h0d
`define CCM_ST_EBUSY 8'h10
`define CCM_ST_EINVAL 8'h16
`define CCM_ST_ERANGE 8'h22
`define CCM_OP_START 2'h0
`define CCM_OP_STOP 2'h1
`define CCM_OP_WR 2'h2
`define CCM_OP_RD 2'h3
`endif

// ### hw/ccm_qtick.v
// Quarter bit period tick generator for the two-wire master.
// Assumes quarter is at least one and stable while run is high.
`timescale 1ns/1ps
module ccm_qtick (
	input wire clock,
	input wire rst,
	input wire run,
	input wire [7:0] quarter,
	output reg tick
);
	reg [7:0] cnt_reg;
	always @(posedge clock) begin
		if (rst || !run) begin
			cnt_reg <= 8'h00;
			tick <= 1'b0;
		end else if (cnt_reg >= quarter - 8'h01) begin
			cnt_reg <= 8'h00;
			tick <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
			tick <= 1'b0;
		end
	end
endmodule

// ### hw/ccm_link.v
// Two-wire bit engine: start, stop, byte write and byte read.
// Assumes scl_s and sda_s are already synchronised; enables pull low.
`timescale 1ns/1ps
`include "ccm_defines.vh"
module ccm_link (
	input wire clock,
	input wire rst,
	input wire tick,
	input wire go,
	input wire [1:0] op,
	input wire [7:0] tx_byte,
	input wire ack_out,
	input wire scl_s,
	input wire sda_s,
	output reg busy,
	output reg done,
	output reg [7:0] rx_byte,
	output reg nack,
	output reg arb_lost,
	output reg scl_oe,
	output reg sda_oe
);
	reg [1:0] op_reg;
	reg [1:0] q_reg;
	reg [3:0] bit_reg;
	reg [7:0] sh_reg;
	wire byte_op = op_reg[1];
	wire last_q = (q_reg == 2'h3);
	// Clock stretching: hold the high phase until the slave lets go
	wire stall = (q_reg == 2'h2) && !scl_s;
	always @(posedge clock) begin
		done <= 1'b0;
		if (rst) begin
			busy <= 1'b0;
			op_reg <= 2'h0;
			q_reg <= 2'h0;
			bit_reg <= 4'h0;
			sh_reg <= 8'h00;
			rx_byte <= 8'h00;
			nack <= 1'b0;
			arb_lost <= 1'b0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
		end else if (!busy) begin
			if (go) begin
				busy <= 1'b1;
				op_reg <= op;
				sh_reg <= tx_byte;
				q_reg <= 2'h0;
				bit_reg <= 4'h0;
				nack <= 1'b0;
				arb_lost <= 1'b0;
			end
		end else if (tick && !stall) begin
			q_reg <= q_reg + 2'h1;
			case (q_reg)
			2'h0: begin
				if (op_reg == `CCM_OP_START)
					sda_oe <= 1'b0;
				else if (op_reg == `CCM_OP_STOP)
					sda_oe <= 1'b1;
				else if (bit_reg == 4'h8)
					sda_oe <= (op_reg == `CCM_OP_RD) && ack_out;
				else
					sda_oe <= (op_reg == `CCM_OP_WR) && !sh_reg[7];
			end
			2'h1: scl_oe <= 1'b0;
			2'h2: begin
				if (op_reg == `CCM_OP_START)
					sda_oe <= 1'b1;
				else if (op_reg == `CCM_OP_STOP)
					sda_oe <= 1'b0;
				else if (bit_reg == 4'h8) begin
					nack <= sda_s;
				end else if (op_reg == `CCM_OP_WR) begin
					// Released high but read low: another master won
					if (sh_reg[7] && !sda_s) begin
						arb_lost <= 1'b1;
						busy <= 1'b0;
						done <= 1'b1;
					end
					sh_reg <= {sh_reg[6:0], 1'b0};
				end else
					sh_reg <= {sh_reg[6:0], sda_s};
			end
			default: begin
				if (op_reg != `CCM_OP_STOP)
					scl_oe <= 1'b1;
				if (byte_op && bit_reg != 4'h8)
					bit_reg <= bit_reg + 4'h1;
				else begin
					busy <= 1'b0;
					done <= 1'b1;
					rx_byte <= sh_reg;
				end
			end
			endcase
		end
		if (last_q && !busy)
			q_reg <= 2'h0;
	end
endmodule

// ### dv/ccm_top_asserts.sv
// Checker for the command port of ccm_top.
// Sees only top ports; mirrors the first pool bytes from parameter writes.
`timescale 1ns/1ps
`include "ccm_defines.vh"
module ccm_top_asserts (
	input wire clock,
	input wire rst,
	input wire host_lock_held,
	input wire param_wr,
	input wire [4:0] param_addr,
	input wire [7:0] param_wdata,
	input wire cmd_valid,
	input wire [15:0] cmd_code,
	input wire rsp_valid,
	input wire [7:0] rsp_status,
	input wire [4:0] rsp_len
);
	reg [7:0] pool_reg [0:5];
	wire lk = cmd_valid && host_lock_held;
	wire [31:0] spd = {pool_reg[0], pool_reg[1], pool_reg[2], pool_reg[3]};
	wire spd_ok = spd >= `CCM_SPEED_MIN && spd <= `CCM_SPEED_MAX;
	always @(posedge clock) begin
		if (param_wr && param_addr < 5'h06)
			pool_reg[param_addr] <= param_wdata;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_reply;
		rsp_valid ##1 !rsp_valid;
	endsequence
	sequence s_said(logic [7:0] st);
		rsp_valid && rsp_status == st;
	endsequence
	reply_pulse_a: assert property (cmd_valid && cmd_code != `CCM_CMD_CONFIG |=> s_reply) else $error("answer not a one-cycle pulse");
	no_lock_a: assert property (cmd_valid && !host_lock_held |=> s_said(`CCM_ST_EACCES)) else $error("unlocked command not refused");
	rd_range_a: assert property (lk && cmd_code == `CCM_CMD_READ && (pool_reg[2] == 8'h00 || pool_reg[2] > `CCM_RD_MAX) |=> rsp_valid && rsp_status inside {`CCM_ST_ERANGE, `CCM_ST_EBUSY}) else $error("bad read length accepted");
	wr_range_a: assert property (lk && cmd_code == `CCM_CMD_WRITE && (pool_reg[2] == 8'h00 || pool_reg[2] > `CCM_WR_MAX) |=> rsp_valid && rsp_status inside {`CCM_ST_ERANGE, `CCM_ST_EBUSY}) else $error("bad write length accepted");
	sel_answer_a: assert property (lk && cmd_code == `CCM_CMD_SELECT |=> rsp_valid && rsp_status inside {`CCM_ST_ENOERR, `CCM_ST_EBUSY}) else $error("select answer wrong");
	stat_answer_a: assert property (lk && cmd_code == `CCM_CMD_STATUS |=> rsp_valid && rsp_status inside {`CCM_ST_ENOERR, `CCM_ST_ENOENT, `CCM_ST_EIO, `CCM_ST_EBUSY}) else $error("status code wrong");
	data_only_ok_a: assert property (rsp_valid && rsp_status != `CCM_ST_ENOERR |-> rsp_len == 5'h00) else $error("data with failure");
	speed_range_a: assert property (lk && cmd_code == `CCM_CMD_CONFIG && !spd_ok |=> rsp_valid && rsp_status inside {`CCM_ST_EINVAL, `CCM_ST_EBUSY}) else $error("bad speed accepted");
	cfg_answer_a: assert property (lk && cmd_code == `CCM_CMD_CONFIG && spd_ok |-> ##[1:127] rsp_valid) else $error("config never answered");
endmodule
bind ccm_top ccm_top_asserts u_chk (.clock(clock), .rst(rst),
	.host_lock_held(host_lock_held), .param_wr(param_wr),
	.param_addr(param_addr), .param_wdata(param_wdata),
	.cmd_valid(cmd_valid), .cmd_code(cmd_code), .rsp_valid(rsp_valid),
	.rsp_status(rsp_status), .rsp_len(rsp_len));

// ### dv/ccm_slave_model.sv
// Behavioural two-wire register slave with 16-bit register pointer.
// Wires are resolved by the bench; outputs pull low when high.
`timescale 1ns/1ps
module ccm_slave_model #(
	parameter [6:0] SADDR = 7'h36 // Arbitrary bus address
) (
	input wire scl,
	input wire sda,
	input wire slow,
	output reg scl_oe,
	output reg sda_oe
);
	reg [7:0] mem [0:255];
	reg [7:0] sh;
	reg [15:0] ptr;
	reg act, rd, mack;
	integer bitn, byten, i;
	initial begin
		scl_oe = 0;
		sda_oe = 0;
		act = 0;
		for (i = 0; i < 256; i = i + 1)
			mem[i] = i[7:0] ^ 8'h5a;
	end
	always @(negedge sda) begin
		if (scl === 1'b1) begin
			act = 1;
			rd = 0;
			mack = 1;
			bitn = -1;
			byten = 0;
		end
	end
	always @(posedge sda) begin
		if (scl === 1'b1)
			act = 0;
	end
	always @(posedge scl) begin
		if (act && !rd && bitn < 8)
			sh = {sh[6:0], sda};
		else if (act && rd && bitn == 8)
			mack = ~sda;
	end
	always @(negedge scl) begin
		if (act) begin
			bitn = bitn + 1;
			if (bitn == 8 && !rd) begin
				if (byten == 0) begin
					act = sh[7:1] == SADDR;
					rd = sh[0];
				end else if (byten == 1)
					ptr[15:8] = sh;
				else if (byten == 2)
					ptr[7:0] = sh;
				else begin
					mem[ptr[7:0]] = sh;
					ptr = ptr + 16'h0001;
				end
				sda_oe = act;
				// Stretch the low phase so the master must wait
				if (slow) fork
					begin
						scl_oe = 1;
						#2000 scl_oe = 0;
					end
				join_none
			end else if (bitn == 8)
				sda_oe = 0;
			else if (bitn == 9) begin
				bitn = 0;
				byten = byten + 1;
				sda_oe = 0;
				if (rd && !mack)
					act = 0;
				else if (rd) begin
					sh = mem[ptr[7:0]];
					ptr = ptr + 16'h0001;
					sda_oe = ~sh[7];
				end
			end else if (rd)
				sda_oe = ~sh[7 - bitn];
		end
	end
endmodule

// ### dv/ccm_top_tb.sv
// Self-checking bench for ccm_top against a two-wire slave model.
// Slave sits at the active sensor address; pull-ups resolve the wires.
`timescale 1ns/1ps
`include "ccm_defines.vh"
module ccm_top_tb;
	reg clock = 0;
	reg rst = 1;
	reg host_lock_held = 0;
	reg param_wr = 0;
	reg cmd_valid = 0;
	reg slow = 0;
	reg jam = 0;
	reg [4:0] param_addr = 0;
	reg [4:0] rsp_rd_addr = 0;
	reg [7:0] param_wdata = 0;
	reg [15:0] cmd_code = 0;
	wire rsp_valid, m_scl, m_sda, s_scl, s_sda, m_sclo, m_sdao;
	wire [7:0] rsp_status, rsp_rd_data;
	wire [4:0] rsp_len;
	wire scl = ~(m_scl | s_scl);
	// Jam stands in for a second master holding the data line low
	wire sda = ~(m_sda | s_sda | jam);
	reg [7:0] ref_mem [0:255];
	reg [15:0] udat, umask, old;
	integer n_fail = 0;
	integer checks_done = 0;
	integer seed = 48;
	integer i, k;
	always #10 clock = ~clock;
	ccm_top u_dut (.clock(clock), .rst(rst), .host_lock_held(host_lock_held),
		.active_sensor_bus_addr(8'h6c), .param_wr(param_wr),
		.param_addr(param_addr), .param_wdata(param_wdata),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .rsp_valid(rsp_valid),
		.rsp_status(rsp_status), .rsp_len(rsp_len),
		.rsp_rd_addr(rsp_rd_addr), .rsp_rd_data(rsp_rd_data),
		.scl_in(scl), .scl_out(m_sclo), .scl_oe(m_scl),
		.sda_in(sda), .sda_out(m_sdao), .sda_oe(m_sda));
	ccm_slave_model u_slv (.scl(scl), .sda(sda), .slow(slow),
		.scl_oe(s_scl), .sda_oe(s_sda));
	task final_report;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task put(input [4:0] a, input [7:0] d);
		@(negedge clock);
		param_wr = 1;
		param_addr = a;
		param_wdata = d;
		@(negedge clock);
		param_wr = 0;
	endtask
	task go(input [15:0] c);
		@(negedge clock);
		cmd_code = c;
		cmd_valid = 1;
		@(negedge clock);
		cmd_valid = 0;
		k = 0;
		while (rsp_valid !== 1'b1 && k < 300) begin
			@(negedge clock);
			k = k + 1;
		end
		if (rsp_valid !== 1'b1) begin
			n_fail = n_fail + 1;
			final_report;
		end
	endtask
	task cmd(input [15:0] c, input [7:0] e);
		go(c);
		chk(rsp_status, e);
	endtask
	task prm(input [15:0] a, input [7:0] l);
		put(5'h00, a[15:8]);
		put(5'h01, a[7:0]);
		put(5'h02, l);
	endtask
	task cfg(input [31:0] s, input [7:0] e);
		for (i = 0; i < 4; i = i + 1)
			put(i[4:0], s[31 - 8 * i -: 8]);
		cmd(`CCM_CMD_CONFIG, e);
	endtask
	// Status is polled sparsely; a bus byte takes over a thousand clocks
	task poll(input [7:0] e);
		integer n;
		n = 0;
		go(`CCM_CMD_STATUS);
		while (rsp_status === `CCM_ST_EBUSY && n < 1000) begin
			repeat (40) @(negedge clock);
			go(`CCM_CMD_STATUS);
			n = n + 1;
		end
		chk(rsp_status, e);
		if (n == 1000) begin
			n_fail = n_fail + 1;
			final_report;
		end
	endtask
	task rdchk(input [15:0] a, input [7:0] l);
		integer j;
		prm(a, l);
		cmd(`CCM_CMD_READ, `CCM_ST_ENOERR);
		poll(`CCM_ST_ENOERR);
		chk(rsp_len, l);
		for (j = 0; j < l; j = j + 1) begin
			@(negedge clock);
			rsp_rd_addr = j[4:0];
			@(negedge clock);
			chk(rsp_rd_data, ref_mem[a[7:0] + j]);
		end
	endtask
	initial begin
		for (i = 0; i < 256; i = i + 1)
			ref_mem[i] = i[7:0] ^ 8'h5a;
		repeat (4) @(negedge clock);
		rst = 0;
		for (i = 0; i < 6; i = i + 1)
			cmd(`CCM_CMD_CONFIG + i[15:0], `CCM_ST_EACCES);
		host_lock_held = 1;
		cmd(`CCM_CMD_STATUS, `CCM_ST_ENOERR);
		chk(rsp_len, 0);
		cmd(16'h8d09, `CCM_ST_EINVAL);
		$display("lock and codes done");
		cfg(32'd99999, `CCM_ST_EINVAL);
		cfg(32'd400001, `CCM_ST_EINVAL);
		cfg(32'd100000, `CCM_ST_ENOERR);
		cfg(32'd400000, `CCM_ST_ENOERR);
		for (i = 0; i < 4; i = i + 1) begin
			prm(16'h0040, i[0] ? (i[1] ? 8'd20 : 8'd23) : 8'd0);
			cmd(i[1] ? `CCM_CMD_WRITE : `CCM_CMD_READ, `CCM_ST_ERANGE);
		end
		cmd(`CCM_CMD_STATUS, `CCM_ST_ENOERR);
		$display("config and range done");
		put(5'h00, 8'h00);
		cmd(`CCM_CMD_SELECT, `CCM_ST_ENOERR);
		prm(16'h0040, 8'd19);
		for (i = 0; i < 19; i = i + 1) begin
			udat = $random(seed);
			ref_mem[8'h40 + i] = udat[7:0];
			put(5'h03 + i[4:0], udat[7:0]);
		end
		cmd(`CCM_CMD_WRITE, `CCM_ST_ENOERR);
		cmd(`CCM_CMD_SELECT, `CCM_ST_EBUSY);
		cmd(`CCM_CMD_READ, `CCM_ST_EBUSY);
		cmd(`CCM_CMD_STATUS, `CCM_ST_EBUSY);
		poll(`CCM_ST_ENOERR);
		chk(rsp_len, 0);
		$display("write done");
		udat = $random(seed);
		umask = $random(seed);
		old = {ref_mem[8'h45], ref_mem[8'h46]};
		old = (old & ~umask) | udat;
		ref_mem[8'h45] = old[15:8];
		ref_mem[8'h46] = old[7:0];
		prm(16'h0045, udat[15:8]);
		put(5'h03, udat[7:0]);
		put(5'h04, umask[15:8]);
		put(5'h05, umask[7:0]);
		slow = 1;
		cmd(`CCM_CMD_UPDATE, `CCM_ST_ENOERR);
		poll(`CCM_ST_ENOERR);
		slow = 0;
		chk(rsp_len, 0);
		rdchk(16'h0040, 8'd22);
		$display("update and read done");
		put(5'h00, 8'ha0);
		cmd(`CCM_CMD_SELECT, `CCM_ST_ENOERR);
		prm(16'h0000, 8'd1);
		cmd(`CCM_CMD_READ, `CCM_ST_ENOERR);
		poll(`CCM_ST_ENOENT);
		chk(rsp_len, 0);
		$display("absent target done");
		jam = 1;
		cmd(`CCM_CMD_WRITE, `CCM_ST_ENOERR);
		poll(`CCM_ST_EIO);
		jam = 0;
		chk(rsp_len, 0);
		chk({m_sclo, m_sdao}, 0);
		$display("lost bus done");
		final_report;
	end
endmodule
